// ==== shared/sstx_pkg.sv ====
// Summary of operation
// - idle, enabled, start-of-message: two-bit delay, first flag bit raises done and active
// - flags repeat while start-of-message stays set at each flag end
// - after last opening flag go transparent and start check accumulation
// - transparent data gets a zero after five consecutive ones
// - end-of-message: finish character, send 16-bit check if enabled, then flag
// - with enable and end-of-message, done rises as closing flag starts
// - enable dropped: finish unit, wait one and a half bits, then idle
// - end-of-message held: flags continue, no underrun, done rises per flag
// - new data during closing flag gives one-flag frame separation, no start needed
// - enable dropped before closing flag: done rises only on return to idle
// - done rises at check start and at closing flag start; rewrite clears it unless done rises in that cycle
// - char mode sends host-supplied sync bytes, done as each one starts
// - char mode first data byte after sync and all later ones enter check
// - char mode end-of-message sends check after current byte, done at its start
// - no automatic idle sync bytes; every sync comes from the buffer
// - check active when bit 9 clear; polynomial chosen by protocol mode
// - check covers host data only; inserted zeros are excluded
// - start initialises check to zeros or ones; bit mode sends it inverted
// - no valid data at character end without end-of-message sets underrun
// - after underrun send aborts in bit mode, hold mark in char mode
// - a buffer write clears done unless done rises in the same cycle; reset sets done
// - protocol select clear means flag framing, set means sync framing
package sstx_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PARAM = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;

  // control register fields
  localparam int CTRL_SEND = 0;
  localparam int CTRL_ABORT = 1;
  localparam int CTRL_ACTIVE = 4;
  localparam int CTRL_DONE = 7;
  localparam int CTRL_LATE = 15;

  // parameter register fields
  localparam int PARAM_CHAR = 8;
  localparam int PARAM_NOCRC = 9;

  // data buffer fields
  localparam int DATA_SOM = 8;
  localparam int DATA_EOM = 9;

  // line patterns, sent least significant bit first
  localparam logic [15:0] FLAG_WORD = 16'h007e;
  localparam logic [15:0] ABORT_WORD = 16'h00ff;
  localparam logic [15:0] MARK_WORD = 16'hffff;
  localparam logic [3:0] LEN_CHAR = 4'd7;
  localparam logic [3:0] LEN_CRC = 4'd15;
  localparam logic [3:0] LEN_MARK = 4'd0;

  // bit-reversed polynomials for lsb-first serial division
  localparam logic [15:0] POLY_BIT = 16'h8408;
  localparam logic [15:0] POLY_CHAR = 16'ha001;
  localparam logic [15:0] CRC_INIT_BIT = 16'hffff;
  localparam logic [15:0] CRC_INIT_CHAR = 16'h0000;

  // timing in link bit times, tail delay in half-bit times
  localparam logic [1:0] LEAD_BITS = 2'd2;
  localparam logic [1:0] TAIL_HALF_BITS = 2'd3;
  localparam logic [2:0] STUFF_RUN = 3'd5;

  // reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_LEAD = 3'b001,
    S_FLAG = 3'b011,
    S_DATA = 3'b010,
    S_CRC = 3'b110,
    S_TAIL = 3'b111,
    S_ABORT = 3'b101,
    S_MARK = 3'b100
  } state_t;

endpackage

// ==== src/sync_serial_frame_transmitter.sv ====
`timescale 1ns/100ps
module sync_serial_frame_transmitter (
  input wire logic core_clk,
  input wire logic resetn,
  input wire sstx_pkg::bus_req_t reg_req,
  output logic [15:0] rdata,
  input wire logic tx_clk_in,
  output logic tx_line
);
  import sstx_pkg::*;

  // ----------------------------------------
  // checksum step
  // ----------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b,
                                           input logic [15:0] poly);
    logic fb;
    fb = c[0] ^ b;
    crc_step = (c >> 1) ^ (fb ? poly : 16'h0000);
  endfunction

  // ----------------------------------------
  // registers seen by software
  // ----------------------------------------
  logic send_q, abort_req_q, char_mode_q, no_crc_q;
  logic [7:0] buf_q;
  logic som_q, eom_q, valid_q;
  logic done_q, active_q, late_q;
  logic [15:0] rdata_q;

  wire wr_ctrl = reg_req.wr && reg_req.addr == OFS_CTRL;
  wire wr_param = reg_req.wr && reg_req.addr == OFS_PARAM;
  wire wr_data = reg_req.wr && reg_req.addr == OFS_DATA;

  // ----------------------------------------
  // link clock sampling
  // ----------------------------------------
  logic txc_s1_q, txc_s2_q, txc_s3_q;
  // data changes on the falling edge so the modem samples a settled rising edge
  wire fall_tick = txc_s3_q && !txc_s2_q;
  wire rise_tick = !txc_s3_q && txc_s2_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // modem clock idles high; matching it avoids a false edge after reset
      txc_s1_q <= 1'b1;
      txc_s2_q <= 1'b1;
      txc_s3_q <= 1'b1;
    end else begin
      txc_s1_q <= tx_clk_in;
      txc_s2_q <= txc_s1_q;
      txc_s3_q <= txc_s2_q;
    end
  end

  // ----------------------------------------
  // serialiser state
  // ----------------------------------------
  state_t state_q, next_s;
  logic [15:0] sh_q, crc_q, crc_d, next_word;
  logic [3:0] bits_q, next_len;
  logic [2:0] ones_q, ones_d;
  logic [1:0] cnt_q;
  logic sync_q, line_q;
  logic late_now;

  wire crc_on = !no_crc_q;
  wire [15:0] poly = char_mode_q ? POLY_CHAR : POLY_BIT;
  wire [15:0] crc_init = char_mode_q ? CRC_INIT_CHAR : CRC_INIT_BIT;
  wire unit_state = state_q == S_FLAG || state_q == S_DATA || state_q == S_CRC ||
                    state_q == S_ABORT || state_q == S_MARK;
  wire transparent = !char_mode_q && (state_q == S_DATA || state_q == S_CRC);
  wire stuff_now = fall_tick && transparent && ones_q == STUFF_RUN;
  wire lead_end = fall_tick && state_q == S_LEAD && cnt_q == LEAD_BITS - 2'd1;
  wire unit_end = lead_end || (fall_tick && unit_state && !stuff_now && bits_q == 4'd0);
  wire start_go = state_q == S_IDLE && send_q && som_q;
  wire tail_edge = state_q == S_TAIL && (fall_tick || rise_tick);
  wire tail_done = tail_edge && cnt_q == TAIL_HALF_BITS - 2'd1;

  // ----------------------------------------
  // choice of the next unit on the line
  // ----------------------------------------
  wire [2:0] start_unit = char_mode_q ? S_DATA : S_FLAG;
  wire [2:0] late_unit = char_mode_q ? S_MARK : S_ABORT;

  always_comb begin
    next_s = state_q;
    late_now = 1'b0;
    case (state_q)
      S_LEAD: begin
        next_s = state_t'(start_unit);
      end
      S_FLAG: begin
        if (!send_q) begin
          next_s = S_TAIL;
        end else if (abort_req_q) begin
          next_s = S_ABORT;
        end else if (som_q || eom_q) begin
          next_s = S_FLAG;
        end else if (valid_q) begin
          next_s = S_DATA;
        end else begin
          next_s = state_t'(late_unit);
          late_now = 1'b1;
        end
      end
      S_DATA: begin
        if (!send_q) begin
          next_s = S_TAIL;
        end else if (char_mode_q && som_q) begin
          next_s = S_DATA;
        end else if (eom_q) begin
          next_s = crc_on ? S_CRC : (char_mode_q ? S_MARK : S_FLAG);
        end else if (valid_q) begin
          next_s = S_DATA;
        end else begin
          next_s = state_t'(late_unit);
          late_now = 1'b1;
        end
      end
      S_CRC: begin
        if (!send_q) begin
          next_s = S_TAIL;
        end else if (!char_mode_q) begin
          next_s = S_FLAG;
        end else begin
          next_s = valid_q ? S_DATA : S_MARK;
        end
      end
      S_ABORT, S_MARK: begin
        if (!send_q) begin
          next_s = S_TAIL;
        end else if (som_q) begin
          next_s = state_t'(start_unit);
        end else begin
          next_s = state_q;
        end
      end
      default: begin
        next_s = state_q;
      end
    endcase
  end

  always_comb begin
    case (next_s)
      S_FLAG: begin
        next_word = FLAG_WORD;
        next_len = LEN_CHAR;
      end
      S_ABORT: begin
        next_word = ABORT_WORD;
        next_len = LEN_CHAR;
      end
      S_DATA: begin
        next_word = {8'h00, buf_q};
        next_len = LEN_CHAR;
      end
      S_CRC: begin
        next_word = char_mode_q ? crc_q : ~crc_q;
        next_len = LEN_CRC;
      end
      default: begin
        next_word = MARK_WORD;
        next_len = LEN_MARK;
      end
    endcase
  end

  // ----------------------------------------
  // bit emission, zero insertion, checksum
  // ----------------------------------------
  wire [2:0] cur_s = unit_end ? next_s : state_q;
  wire cur_sync = unit_end ? (char_mode_q && som_q) : sync_q;
  wire load_data = unit_end && next_s == S_DATA;
  wire bit_out = stuff_now ? 1'b0 : (unit_end ? next_word[0] : sh_q[0]);
  wire cur_transp = !char_mode_q && (cur_s == S_DATA || cur_s == S_CRC);
  wire crc_init_now = unit_end && (next_s == S_FLAG || (load_data && char_mode_q && som_q));
  // inserted zeros never reach this path since stuff_now blocks it
  wire crc_bit = fall_tick && !stuff_now && cur_s == S_DATA && !cur_sync && crc_on;
  wire done_set = (unit_end && send_q && (next_s == S_FLAG || next_s == S_DATA ||
                  next_s == S_CRC)) || (tail_done && eom_q);

  always_comb begin
    crc_d = crc_q;
    if (crc_init_now) begin
      crc_d = crc_init;
    end else if (crc_bit) begin
      crc_d = crc_step(crc_q, bit_out, poly);
    end
    ones_d = ones_q;
    if (stuff_now) begin
      ones_d = 3'd0;
    end else if (fall_tick && (unit_state || lead_end)) begin
      ones_d = (cur_transp && bit_out) ? ones_q + 3'd1 : 3'd0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      sh_q <= MARK_WORD;
      bits_q <= 4'd0;
      cnt_q <= 2'd0;
      sync_q <= 1'b0;
      line_q <= 1'b1;
      crc_q <= RST_ZERO;
      ones_q <= 3'd0;
    end else begin
      crc_q <= crc_d;
      ones_q <= ones_d;
      if (start_go) begin
        state_q <= S_LEAD;
        cnt_q <= 2'd0;
      end else if (state_q == S_LEAD && fall_tick && !lead_end) begin
        cnt_q <= cnt_q + 2'd1;
      end else if (tail_done) begin
        state_q <= S_IDLE;
      end else if (tail_edge) begin
        cnt_q <= cnt_q + 2'd1;
      end
      if (unit_end) begin
        state_q <= next_s;
        sync_q <= char_mode_q && som_q;
        cnt_q <= 2'd0;
        if (next_s == S_TAIL) begin
          line_q <= 1'b1;
        end else begin
          line_q <= next_word[0];
          sh_q <= next_word >> 1;
          bits_q <= next_len;
        end
      end else if (fall_tick && unit_state) begin
        line_q <= bit_out;
        if (!stuff_now) begin
          sh_q <= sh_q >> 1;
          bits_q <= bits_q - 4'd1;
        end
      end
    end
  end

  // ----------------------------------------
  // software register file
  // ----------------------------------------
  logic [15:0] ctrl_word, param_word;

  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[CTRL_LATE] = late_q;
    ctrl_word[CTRL_DONE] = done_q;
    ctrl_word[CTRL_ACTIVE] = active_q;
    ctrl_word[CTRL_ABORT] = abort_req_q;
    ctrl_word[CTRL_SEND] = send_q;
    param_word = 16'h0000;
    param_word[PARAM_NOCRC] = no_crc_q;
    param_word[PARAM_CHAR] = char_mode_q;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      send_q <= 1'b0;
      abort_req_q <= 1'b0;
      char_mode_q <= 1'b0;
      no_crc_q <= 1'b0;
      buf_q <= 8'h00;
      som_q <= 1'b0;
      eom_q <= 1'b0;
      valid_q <= 1'b0;
      done_q <= 1'b1;
      active_q <= 1'b0;
      late_q <= 1'b0;
      rdata_q <= RST_ZERO;
    end else begin
      if (wr_ctrl) begin
        send_q <= reg_req.wdata[CTRL_SEND];
        abort_req_q <= reg_req.wdata[CTRL_ABORT];
      end
      if (wr_param) begin
        char_mode_q <= reg_req.wdata[PARAM_CHAR];
        no_crc_q <= reg_req.wdata[PARAM_NOCRC];
      end
      if (wr_data) begin
        buf_q <= reg_req.wdata[7:0];
        som_q <= reg_req.wdata[DATA_SOM];
        eom_q <= reg_req.wdata[DATA_EOM];
      end
      // a write in the same cycle as the load keeps the new byte valid
      // an end-of-message write carries no character to send
      valid_q <= (wr_data && !reg_req.wdata[DATA_EOM]) || (valid_q && !load_data);
      done_q <= done_set || (done_q && !wr_data);
      late_q <= (unit_end && late_now) ||
                (late_q && !(wr_data && reg_req.wdata[DATA_SOM]));
      if (lead_end) begin
        active_q <= 1'b1;
      end else if (tail_done) begin
        active_q <= 1'b0;
      end
      rdata_q <= 16'h0000;
      if (reg_req.rd) begin
        case (reg_req.addr)
          OFS_CTRL: begin
            rdata_q <= ctrl_word;
          end
          OFS_PARAM: begin
            rdata_q <= param_word;
          end
          OFS_DATA: begin
            rdata_q <= {6'h00, eom_q, som_q, buf_q};
          end
          default: begin
            rdata_q <= 16'h0000;
          end
        endcase
      end
    end
  end

  assign rdata = rdata_q;
  assign tx_line = line_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_lead_start;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == S_IDLE && send_q && som_q) |=> state_q == S_LEAD && !active_q;
  endproperty
  a_lead_start: assert property (p_lead_start) else $error("start did not enter lead delay");

  property p_first_flag;
    @(posedge core_clk) disable iff (!resetn)
      (lead_end && !char_mode_q && send_q) |=> active_q && done_q && !tx_line;
  endproperty
  a_first_flag: assert property (p_first_flag) else $error("first flag bit without done");

  property p_stuff_limit;
    @(posedge core_clk) disable iff (!resetn)
      ones_q <= STUFF_RUN;
  endproperty
  a_stuff_limit: assert property (p_stuff_limit) else $error("six ones in transparent data");

  property p_stuff_zero;
    @(posedge core_clk) disable iff (!resetn)
      stuff_now |=> !tx_line && ones_q == 3'd0;
  endproperty
  a_stuff_zero: assert property (p_stuff_zero) else $error("inserted bit is not a zero");

  property p_write_clears_done;
    @(posedge core_clk) disable iff (!resetn)
      (wr_data && !done_set) |=> !done_q;
  endproperty
  a_write_clears_done: assert property (p_write_clears_done) else $error("done survived write");

  property p_closing_done;
    @(posedge core_clk) disable iff (!resetn)
      (unit_end && next_s == S_FLAG && send_q && eom_q) |=> done_q && state_q == S_FLAG;
  endproperty
  a_closing_done: assert property (p_closing_done) else $error("closing flag without done");

  property p_late_cause;
    @(posedge core_clk) disable iff (!resetn)
      $rose(late_q) |-> $past(!valid_q) && $past(!eom_q);
  endproperty
  a_late_cause: assert property (p_late_cause) else $error("underrun with data present");

  property p_flag_init;
    @(posedge core_clk) disable iff (!resetn)
      (unit_end && next_s == S_FLAG && !char_mode_q) |=> crc_q == CRC_INIT_BIT;
  endproperty
  a_flag_init: assert property (p_flag_init) else $error("check not preset at flag");

  property p_abort_ones;
    @(posedge core_clk) disable iff (!resetn)
      (fall_tick && state_q == S_ABORT && !unit_end) |=> tx_line;
  endproperty
  a_abort_ones: assert property (p_abort_ones) else $error("abort sent a zero");

  property p_idle_via_tail;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == S_IDLE && $past(state_q) != S_IDLE) |-> $past(state_q) == S_TAIL;
  endproperty
  a_idle_via_tail: assert property (p_idle_via_tail) else $error("idle without tail delay");

endmodule

// ==== testbench/link_modem.sv ====
`timescale 1ns/100ps
module link_modem #(
  parameter realtime HALF_BIT = 32.0
) (
  output logic tx_clk_in,
  input wire logic tx_line
);
  logic bits[$];

  // free-running modem clock, phase unrelated to the core clock
  initial begin
    tx_clk_in = 1'b1;
    #3.7;
    forever #(HALF_BIT) tx_clk_in = ~tx_clk_in;
  end

  // sample on the rising edge, half a bit after the transmitter moves
  always @(posedge tx_clk_in) begin
    bits.push_back(tx_line);
  end
endmodule

// ==== testbench/sync_serial_frame_transmitter_bench.sv ====
`timescale 1ns/100ps
module sync_serial_frame_transmitter_bench;
  import sstx_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  bus_req_t reg_req = '0;
  logic [15:0] rdata;
  logic tx_clk_in;
  logic tx_line;
  int n_fail = 0;
  int checks_done = 0;
  logic e[$];
  int ones;
  bit stuff_on;
  logic [15:0] crc;
  logic [15:0] v;

  always #4 core_clk = ~core_clk;

  sync_serial_frame_transmitter dut_u (
    .core_clk(core_clk),
    .resetn(resetn),
    .reg_req(reg_req),
    .rdata(rdata),
    .tx_clk_in(tx_clk_in),
    .tx_line(tx_line)
  );

  link_modem modem_u (
    .tx_clk_in(tx_clk_in),
    .tx_line(tx_line)
  );

  // ----------------------------------------
  // reporting and bus access
  // ----------------------------------------
  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // polls the control word; a bound that runs out ends the run
  task automatic wait_ctrl(input int pos, input logic val);
    for (int i = 0; i < 3000; i++) begin
      rd(OFS_CTRL, v);
      if (v[pos] === val) begin
        return;
      end
    end
    check("control poll", {15'h0000, v[pos]}, {15'h0000, val});
    stop_test();
  endtask

  // ----------------------------------------
  // expected line stream
  // ----------------------------------------
  task automatic put_bit(input logic b);
    e.push_back(b);
    ones = (stuff_on && b) ? ones + 1 : 0;
    if (ones == 5) begin
      e.push_back(1'b0);
      ones = 0;
    end
  endtask

  task automatic put_flag();
    for (int i = 0; i < 8; i++) begin
      e.push_back(FLAG_WORD[i]);
    end
    ones = 0;
  endtask

  task automatic put_byte(input logic [7:0] d, input logic [15:0] poly, input bit add);
    for (int i = 0; i < 8; i++) begin
      if (add) begin
        crc = (crc[0] ^ d[i]) ? (crc >> 1) ^ poly : crc >> 1;
      end
      put_bit(d[i]);
    end
  endtask

  task automatic put_word(input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      put_bit(w[i]);
    end
  endtask

  function automatic bit has();
    int k;
    for (int s = 0; s + e.size() <= modem_u.bits.size(); s++) begin
      for (k = 0; k < e.size(); k++) begin
        if (modem_u.bits[s + k] !== e[k]) begin
          break;
        end
      end
      if (k == e.size()) begin
        return 1'b1;
      end
    end
    return 1'b0;
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic frame_bit(input bit nocrc, input logic [7:0] d0, input logic [7:0] d1);
    wr(OFS_PARAM, {6'h00, nocrc, 9'h000});
    wr(OFS_CTRL, 16'h0001);
    modem_u.bits.delete();
    wr(OFS_DATA, 16'h0100);
    wait_ctrl(CTRL_ACTIVE, 1'b1);
    rd(OFS_CTRL, v);
    check("done at first flag", v[CTRL_DONE], 1'b1);
    repeat (200) @(posedge core_clk);
    wr(OFS_DATA, {8'h00, d0});
    rd(OFS_CTRL, v);
    check("done after load", v[CTRL_DONE], 1'b0);
    wait_ctrl(CTRL_DONE, 1'b1);
    wr(OFS_DATA, {8'h00, d1});
    wait_ctrl(CTRL_DONE, 1'b1);
    wr(OFS_DATA, 16'h0200);
    if (!nocrc) begin
      wait_ctrl(CTRL_DONE, 1'b1);
      wr(OFS_DATA, 16'h0200);
    end
    wait_ctrl(CTRL_DONE, 1'b1);
    repeat (150) @(posedge core_clk);
    rd(OFS_CTRL, v);
    check("no underrun on held end", v[CTRL_LATE], 1'b0);
    if (!nocrc) begin
      wr(OFS_CTRL, 16'h0003);
      repeat (300) @(posedge core_clk);
      e.delete();
      put_flag();
      repeat (16) e.push_back(1'b1);
      check("abort after flags", has(), 1'b1);
    end
    wr(OFS_CTRL, 16'h0000);
    wait_ctrl(CTRL_ACTIVE, 1'b0);
    e.delete();
    crc = 16'hffff;
    ones = 0;
    stuff_on = 1'b0;
    put_flag();
    put_flag();
    stuff_on = 1'b1;
    put_byte(d0, 16'h8408, !nocrc);
    put_byte(d1, 16'h8408, !nocrc);
    if (!nocrc) begin
      put_word(~crc);
    end
    put_flag();
    put_flag();
    check("bit frame stream", has(), 1'b1);
  endtask

  task automatic frame_char(input logic [7:0] sy, input logic [7:0] d0, input logic [7:0] d1);
    wr(OFS_PARAM, 16'h0100);
    wr(OFS_CTRL, 16'h0001);
    modem_u.bits.delete();
    wr(OFS_DATA, {8'h01, sy});
    wait_ctrl(CTRL_DONE, 1'b1);
    wr(OFS_DATA, {8'h00, d0});
    wait_ctrl(CTRL_DONE, 1'b1);
    wr(OFS_DATA, {8'h00, d1});
    wait_ctrl(CTRL_DONE, 1'b1);
    wr(OFS_DATA, 16'h0200);
    wait_ctrl(CTRL_DONE, 1'b1);
    repeat (300) @(posedge core_clk);
    wr(OFS_CTRL, 16'h0000);
    wait_ctrl(CTRL_ACTIVE, 1'b0);
    e.delete();
    crc = 16'h0000;
    ones = 0;
    stuff_on = 1'b0;
    put_byte(sy, 16'ha001, 1'b0);
    put_byte(d0, 16'ha001, 1'b1);
    put_byte(d1, 16'ha001, 1'b1);
    put_word(crc);
    put_word(16'hffff);
    check("char frame stream", has(), 1'b1);
  endtask

  task automatic underrun();
    wr(OFS_PARAM, 16'h0200);
    wr(OFS_CTRL, 16'h0001);
    modem_u.bits.delete();
    wr(OFS_DATA, 16'h0100);
    wait_ctrl(CTRL_ACTIVE, 1'b1);
    wr(OFS_DATA, 16'h0000);
    wait_ctrl(CTRL_LATE, 1'b1);
    repeat (300) @(posedge core_clk);
    e.delete();
    repeat (16) e.push_back(1'b1);
    check("abort after underrun", has(), 1'b1);
    wr(OFS_DATA, 16'h0100);
    rd(OFS_CTRL, v);
    check("underrun cleared", v[CTRL_LATE], 1'b0);
    wr(OFS_CTRL, 16'h0000);
    wait_ctrl(CTRL_ACTIVE, 1'b0);
  endtask

  task automatic back_to_back(input logic [7:0] d0, input logic [7:0] d1);
    wr(OFS_PARAM, 16'h0200);
    wr(OFS_CTRL, 16'h0001);
    modem_u.bits.delete();
    wr(OFS_DATA, 16'h0100);
    wait_ctrl(CTRL_ACTIVE, 1'b1);
    wr(OFS_DATA, {8'h00, d0});
    wait_ctrl(CTRL_DONE, 1'b1);
    wr(OFS_DATA, 16'h0200);
    wait_ctrl(CTRL_DONE, 1'b1);
    wr(OFS_DATA, {8'h00, d1});
    wait_ctrl(CTRL_DONE, 1'b1);
    wr(OFS_DATA, 16'h0200);
    wait_ctrl(CTRL_DONE, 1'b1);
    wr(OFS_CTRL, 16'h0000);
    wait_ctrl(CTRL_ACTIVE, 1'b0);
    e.delete();
    ones = 0;
    stuff_on = 1'b1;
    put_byte(d0, POLY_BIT, 1'b0);
    put_flag();
    put_byte(d1, POLY_BIT, 1'b0);
    put_flag();
    check("one flag between frames", has(), 1'b1);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    check("idle line", tx_line, 1'b1);
    rd(OFS_CTRL, v);
    check("control reset", v, 16'h0080);
    rd(OFS_PARAM, v);
    check("parameter reset", v, 16'h0000);
    rd(OFS_DATA, v);
    check("buffer reset", v, 16'h0000);
    rd(8'h0c, v);
    check("unmapped read", v, 16'h0000);
    frame_bit(1'b1, 8'hff, 8'h3e);
    frame_bit(1'b0, 8'h5a, 8'hfc);
    frame_char(8'h96, 8'h81, 8'h3c);
    underrun();
    back_to_back(8'h7e, 8'h01);
    stop_test();
  end
endmodule
